// ### hw/bpmf_host.sv
/*
 * Packet-mode host: frames packets toward the framer and parses packets
 * coming back, steered by software over an APB slave.
 * Assumes the byte streams share clk_sys; the receive stream has no stall.
 */
module bpmf_host (
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [7:0]  tx_data,
	output logic             tx_valid,
	input  wire logic        tx_ready,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_valid
);

	// ************************************************************
	// APB slave
	// ************************************************************
	logic                   wr_acc;
	logic                   rd_acc;
	logic                   setup;
	logic                   mapped;
	logic [6:0]             st_r;
	logic [6:0]             st_set;
	logic [31:0]            rd_nxt;
	logic [31:0]            prdata_r;
	logic                   pslverr_r;
	logic [31:0]            ctrl_r;
	logic [23:0]            rxhdr_r;
	logic [31:0]            grp_hdr_r;
	logic [6:0]             rd_ptr_r;
	logic [7:0]             rx_buf [0:bpmf_pkg::MAX_FIELD-1];

	bpmf_pkg::bpmf_tx_state_t state_r;

	assign wr_acc  = psel && penable && pwrite;
	assign rd_acc  = psel && penable && !pwrite;
	assign setup   = psel && !penable;
	assign pready  = 1'b1;
	assign prdata  = prdata_r;
	assign pslverr = pslverr_r;
	assign mapped  = paddr inside {bpmf_pkg::REG_CTRL, bpmf_pkg::REG_TXDATA, bpmf_pkg::REG_STATUS,
		bpmf_pkg::REG_RXHDR, bpmf_pkg::REG_RXDATA, bpmf_pkg::REG_GRPHDR};

	always_comb
	begin
		rd_nxt = 32'h0000_0000;
		unique case (paddr)
			bpmf_pkg::REG_CTRL:   rd_nxt = {ctrl_r[31:1], 1'b0};
			bpmf_pkg::REG_STATUS: rd_nxt = {25'h0, st_r[6:1], state_r == bpmf_pkg::TX_SEND};
			bpmf_pkg::REG_RXHDR:  rd_nxt = {8'h00, rxhdr_r};
			bpmf_pkg::REG_RXDATA: rd_nxt = {24'h0, rx_buf[rd_ptr_r]};
			bpmf_pkg::REG_GRPHDR: rd_nxt = grp_hdr_r;
			default:              rd_nxt = 32'h0000_0000;
		endcase
	end

	// Read data is captured in the setup cycle so a zero-wait access returns it
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			prdata_r  <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end
		else if (setup)
		begin
			prdata_r  <= rd_nxt;
			pslverr_r <= !mapped;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			ctrl_r <= 32'h0000_0000;
		else if (wr_acc && paddr == bpmf_pkg::REG_CTRL)
			ctrl_r <= pwdata;
	end

	// Sticky status: a new event wins over a write-one clear in the same cycle
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			st_r <= 7'h00;
		else if (wr_acc && paddr == bpmf_pkg::REG_STATUS)
			st_r <= (st_r & ~pwdata[6:0]) | st_set;
		else
			st_r <= st_r | st_set;
	end

	// ************************************************************
	// Transmit framing
	// ************************************************************
	logic                   start;
	logic                   adv;
	logic [7:0]             tx_buf [0:bpmf_pkg::MAX_FIELD-1];
	logic [6:0]             wptr_r;
	logic [1:0]             tx_seq_r [0:bpmf_pkg::ADDR_COUNT-1];
	logic [1:0]             tx_seq_rd;
	bpmf_pkg::bpmf_hdr_t    hdr_r;
	logic [23:0]            hdr_bits;
	logic                   grp_mode_r;
	logic [6:0]             total_r;
	logic [6:0]             pos_r;
	logic [15:0]            crc_r;
	logic [7:0]             cur_byte;
	logic [7:0]             tx_data_r;
	logic                   tx_valid_r;
	logic [1:0]             len_code;
	logic [6:0]             ulen_req;
	logic [6:0]             pl_idx;
	logic [31:0]            ctrl_src;

	// Fields come from the write that carries start; ctrl_r only catches up on that edge
	assign ctrl_src  = (wr_acc && paddr == bpmf_pkg::REG_CTRL) ? pwdata : ctrl_r;
	assign len_code  = ctrl_src[bpmf_pkg::CTRL_LEN +: 2];
	assign ulen_req  = ctrl_src[bpmf_pkg::CTRL_ULEN +: 7];
	assign tx_seq_rd = tx_seq_r[ctrl_src[bpmf_pkg::CTRL_ADDR +: 10]];
	// A start while busy is dropped
	assign start     = wr_acc && paddr == bpmf_pkg::REG_CTRL && pwdata[bpmf_pkg::CTRL_START]
		&& state_r == bpmf_pkg::TX_IDLE;
	assign adv       = state_r == bpmf_pkg::TX_SEND && (!tx_valid_r || tx_ready);
	assign hdr_bits  = hdr_r;
	assign pl_idx    = pos_r - bpmf_pkg::HDR_BYTES;
	assign tx_data   = tx_data_r;
	assign tx_valid  = tx_valid_r;

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			wptr_r <= 7'h00;
		else if (state_r == bpmf_pkg::TX_SEND && adv && pos_r == total_r)
			wptr_r <= 7'h00;
		else if (wr_acc && paddr == bpmf_pkg::REG_TXDATA && state_r == bpmf_pkg::TX_IDLE
			&& wptr_r < 7'(bpmf_pkg::MAX_FIELD))
			wptr_r <= wptr_r + 7'h01;
	end

	always_ff @(posedge clk_sys)
	begin
		if (wr_acc && paddr == bpmf_pkg::REG_TXDATA && state_r == bpmf_pkg::TX_IDLE
			&& wptr_r < 7'(bpmf_pkg::MAX_FIELD))
			tx_buf[wptr_r] <= pwdata[7:0];
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			for (int i = 0; i < bpmf_pkg::ADDR_COUNT; i++)
				tx_seq_r[i] <= 2'h0;
		end
		else if (start)
			tx_seq_r[ctrl_src[bpmf_pkg::CTRL_ADDR +: 10]] <= tx_seq_rd + 2'h1; // [R3]
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			hdr_r      <= '0;
			grp_mode_r <= 1'b0;
			total_r    <= bpmf_pkg::PKT_TOTAL[0];
		end
		else if (start)
		begin
			hdr_r.len_code   <= len_code; // [R25]
			hdr_r.seq        <= tx_seq_rd; // [R3]
			hdr_r.first      <= ctrl_src[bpmf_pkg::CTRL_GROUP] && ctrl_src[bpmf_pkg::CTRL_FIRST]; // [R4]
			hdr_r.last       <= ctrl_src[bpmf_pkg::CTRL_GROUP] && ctrl_src[bpmf_pkg::CTRL_LAST]; // [R4]
			hdr_r.addr       <= ctrl_src[bpmf_pkg::CTRL_ADDR +: 10]; // [R5]
			hdr_r.command    <= ctrl_src[bpmf_pkg::CTRL_CMD]; // [R6]
			// Oversized length is clamped so payload never overruns the CRC [R7]
			hdr_r.useful_len <= (ulen_req > bpmf_pkg::PKT_FIELD[len_code]) ?
				bpmf_pkg::PKT_FIELD[len_code] : ulen_req;
			grp_mode_r       <= ctrl_src[bpmf_pkg::CTRL_GROUP];
			total_r          <= bpmf_pkg::PKT_TOTAL[len_code]; // [R1]
		end
	end

	always_comb
	begin
		cur_byte = 8'h00;
		if (pos_r == 7'h00)
			cur_byte = hdr_bits[23:16]; // [R2]
		else if (pos_r == 7'h01)
			cur_byte = hdr_bits[15:8];
		else if (pos_r == 7'h02)
			cur_byte = hdr_bits[7:0];
		else if (pos_r == total_r - bpmf_pkg::CRC_BYTES)
			cur_byte = ~crc_r[15:8]; // [R10]
		else if (pos_r == total_r - 7'h01)
			cur_byte = ~crc_r[7:0];
		else if (pos_r < bpmf_pkg::HDR_BYTES + hdr_r.useful_len)
		begin
			cur_byte = tx_buf[pl_idx];
			// Group opening byte always announces a group CRC [R15] [R24]
			if (grp_mode_r && hdr_r.first && pl_idx == 7'h00)
				cur_byte[bpmf_pkg::GH_CRC] = 1'b1;
		end
		else
			cur_byte = 8'h00; // [R8]
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			state_r    <= bpmf_pkg::TX_IDLE;
			pos_r      <= 7'h00;
			crc_r      <= bpmf_pkg::CRC_PRESET;
			tx_data_r  <= 8'h00;
			tx_valid_r <= 1'b0;
		end
		else
		begin
			unique case (state_r)
				bpmf_pkg::TX_IDLE:
				begin
					if (start)
					begin
						state_r <= bpmf_pkg::TX_SEND;
						pos_r   <= 7'h00;
						crc_r   <= bpmf_pkg::CRC_PRESET; // [R10]
					end
				end
				bpmf_pkg::TX_SEND:
				begin
					if (adv)
					begin
						if (pos_r == total_r)
						begin
							tx_valid_r <= 1'b0;
							state_r    <= bpmf_pkg::TX_IDLE;
						end
						else
						begin
							tx_data_r  <= cur_byte;
							tx_valid_r <= 1'b1;
							pos_r      <= pos_r + 7'h01;
							if (pos_r < total_r - bpmf_pkg::CRC_BYTES)
								crc_r <= bpmf_pkg::bpmf_crc_byte(crc_r, cur_byte); // [R9]
						end
					end
				end
			endcase
		end
	end

	// ************************************************************
	// Receive parsing
	// ************************************************************
	logic [6:0]             rpos_r;
	logic [23:0]            rhdr_r;
	bpmf_pkg::bpmf_hdr_t    rh;
	logic [15:0]            rcrc_r;
	logic [15:0]            rcrc_nxt;
	logic [15:0]            gcrc_r;
	logic [15:0]            gcrc_nxt;
	logic [2:0]             rx_seq_r [0:bpmf_pkg::ADDR_COUNT-1];
	logic [2:0]             rx_seq_rd;
	logic [6:0]             rtotal;
	logic [6:0]             rpl_idx;
	logic                   rx_pl;
	logic                   rx_end;
	logic                   crc_bad;
	logic                   len_bad;
	logic                   seq_bad;
	logic                   rx_good;
	logic                   grp_check;

	assign rh        = rhdr_r;
	assign rtotal    = bpmf_pkg::PKT_TOTAL[rh.len_code];
	assign rpl_idx   = rpos_r - bpmf_pkg::HDR_BYTES;
	assign rx_pl     = rx_valid && rpos_r >= bpmf_pkg::HDR_BYTES
		&& rpos_r < bpmf_pkg::HDR_BYTES + rh.useful_len && rpl_idx < 7'(bpmf_pkg::MAX_FIELD);
	assign rcrc_nxt  = bpmf_pkg::bpmf_crc_byte(rpos_r == 7'h00 ? bpmf_pkg::CRC_PRESET : rcrc_r, rx_data);
	assign gcrc_nxt  = bpmf_pkg::bpmf_crc_byte((rh.first && rpl_idx == 7'h00) ? bpmf_pkg::CRC_PRESET
		: gcrc_r, rx_data); // [R23]
	assign rx_seq_rd = rx_seq_r[rh.addr];
	assign rx_end    = rx_valid && rpos_r != 7'h00 && rpos_r == rtotal - 7'h01;
	assign crc_bad   = rcrc_nxt != bpmf_pkg::CRC_RESIDUE; // [R9]
	assign len_bad   = rh.useful_len > bpmf_pkg::PKT_FIELD[rh.len_code]; // [R26]
	assign seq_bad   = rx_seq_rd[2] && (rx_seq_rd[1:0] + 2'h1) != rh.seq; // [R3]
	// Padding packets are never delivered or sequence-checked; CRC and length errors still flag them [R5]
	assign rx_good   = rx_end && !crc_bad && !len_bad && !seq_bad && rh.addr != bpmf_pkg::PAD_ADDR;
	// Legacy groups without CRC are accepted unchecked [R15]
	assign grp_check = rx_good && rh.last && grp_hdr_r[24 + bpmf_pkg::GH_CRC];

	always_comb
	begin
		st_set = 7'h00;
		st_set[bpmf_pkg::ST_RX_OK]   = rx_good;
		st_set[bpmf_pkg::ST_CRC_ERR] = rx_end && crc_bad; // [R26]
		st_set[bpmf_pkg::ST_SEQ_ERR] = rx_end && !crc_bad && seq_bad && rh.addr != bpmf_pkg::PAD_ADDR;
		st_set[bpmf_pkg::ST_LEN_ERR] = rx_end && !crc_bad && len_bad;
		st_set[bpmf_pkg::ST_GRP_OK]  = rx_good && rh.last && (!grp_check || gcrc_r == bpmf_pkg::CRC_RESIDUE);
		st_set[bpmf_pkg::ST_GRP_ERR] = grp_check && gcrc_r != bpmf_pkg::CRC_RESIDUE; // [R23]
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			rpos_r <= 7'h00;
			rhdr_r <= 24'h000000;
			rcrc_r <= bpmf_pkg::CRC_PRESET;
			gcrc_r <= bpmf_pkg::CRC_PRESET;
		end
		else if (rx_valid)
		begin
			rcrc_r <= rcrc_nxt;
			rpos_r <= rx_end ? 7'h00 : rpos_r + 7'h01;
			if (rpos_r < bpmf_pkg::HDR_BYTES)
				rhdr_r <= {rhdr_r[15:0], rx_data}; // [R25]
			if (rx_pl && (rh.first || rh.last))
				gcrc_r <= gcrc_nxt;
		end
	end

	// Payload lands in place; a discarded packet may leave stale bytes behind
	always_ff @(posedge clk_sys)
	begin
		if (rx_pl)
			rx_buf[rpl_idx] <= rx_data; // [R7]
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			for (int i = 0; i < bpmf_pkg::ADDR_COUNT; i++)
				rx_seq_r[i] <= 3'h0;
		end
		else if (rx_end && !crc_bad && rh.addr != bpmf_pkg::PAD_ADDR)
			rx_seq_r[rh.addr] <= {1'b1, rh.seq}; // Resynchronise after a gap
	end

	// Flags, type, continuity, repetition, then segment or access bytes [R13] [R14] [R16] [R17]
	// [R19] [R20] [R21] [R22]
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			grp_hdr_r <= 32'h0000_0000;
		else if (rx_pl && rh.first && rpl_idx < 7'h04)
			grp_hdr_r[8 * (3 - rpl_idx[1:0]) +: 8] <= rx_data; // [R24]
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			rxhdr_r <= 24'h000000;
		else if (rx_good)
			rxhdr_r <= rhdr_r;
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			rd_ptr_r <= 7'h00;
		else if (rx_good)
			rd_ptr_r <= 7'h00;
		else if (rd_acc && paddr == bpmf_pkg::REG_RXDATA && rd_ptr_r < 7'(bpmf_pkg::MAX_FIELD - 1))
			rd_ptr_r <= rd_ptr_r + 7'h01;
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	property p_hdr_first;
		start |=> ##1 (tx_valid && tx_data == hdr_bits[23:16]);
	endproperty
	a_hdr_first: assert property (p_hdr_first) else $error("Header byte not sent first"); // [R2]

	property p_seq_next;
		start |=> hdr_r.seq == $past(tx_seq_rd) && tx_seq_rd == $past(tx_seq_rd) + 2'h1;
	endproperty
	a_seq_next: assert property (p_seq_next) else $error("Continuity counter misused"); // [R3]

	property p_flags_zero;
		state_r == bpmf_pkg::TX_SEND && !grp_mode_r |-> !hdr_r.first && !hdr_r.last;
	endproperty
	a_flags_zero: assert property (p_flags_zero) else $error("Flags set outside group mode"); // [R4]

	property p_total;
		state_r == bpmf_pkg::TX_SEND |-> total_r == bpmf_pkg::PKT_TOTAL[hdr_r.len_code];
	endproperty
	a_total: assert property (p_total) else $error("Packet size does not follow code"); // [R1]

	property p_pad_zero;
		adv && pos_r >= bpmf_pkg::HDR_BYTES + hdr_r.useful_len && pos_r < total_r - bpmf_pkg::CRC_BYTES
			|=> tx_data == 8'h00;
	endproperty
	a_pad_zero: assert property (p_pad_zero) else $error("Padding byte not zero"); // [R8]

	property p_crc_inv;
		adv && pos_r == total_r - 7'h01 |=> tx_data == ~crc_r[7:0] && $stable(crc_r);
	endproperty
	a_crc_inv: assert property (p_crc_inv) else $error("CRC not sent inverted"); // [R10]

	property p_rx_crc;
		rx_end && crc_bad |-> !rx_good ##1 !st_r[bpmf_pkg::ST_RX_OK] || $past(st_r[bpmf_pkg::ST_RX_OK]);
	endproperty
	a_rx_crc: assert property (p_rx_crc) else $error("Bad CRC packet accepted"); // [R9]

	property p_pad_drop;
		rx_good |-> rh.addr != bpmf_pkg::PAD_ADDR && rh.useful_len <= 7'(bpmf_pkg::MAX_FIELD);
	endproperty
	a_pad_drop: assert property (p_pad_drop) else $error("Padding or oversize packet delivered"); // [R5]

	property p_ulen;
		state_r == bpmf_pkg::TX_SEND |-> hdr_r.useful_len <= bpmf_pkg::PKT_FIELD[hdr_r.len_code];
	endproperty
	a_ulen: assert property (p_ulen) else $error("Useful length beyond field"); // [R7]

	c_tx_done: cover property (state_r == bpmf_pkg::TX_SEND ##1 state_r == bpmf_pkg::TX_IDLE);
	c_rx_good: cover property (rx_good);
	c_rx_seq:  cover property (st_set[bpmf_pkg::ST_SEQ_ERR]);
	c_grp_ok:  cover property (st_set[bpmf_pkg::ST_GRP_OK] && grp_check);

endmodule

// ### include/bpmf_pkg.sv
/*
 * Constants, types and the CRC step for the packet-mode host controller.
 * Assumes one byte clock and a synchronous active-high reset in every user.
 */
// Contract
// R1: Length code selects 24/48/72/96 byte packets
// R2: Three header bytes, data field, two CRC
// R3: Two-bit continuity counter per address, wraps
// R4: First/last flags zero without data groups
// R5: Address zero only for padding packets
// R6: Command flag: zero data, one command
// R7: Seven-bit useful length, zero to 91
// R8: Data field padded with zero bytes
// R9: Packet CRC x16+x12+x5+1 over header, field
// R10: CRC preset all ones, sent inverted
// R11: Per-address packet order kept by multiplexer
// R12: Whole packets per frame, padding packets
// R13: Group: header, session header, payload, CRC
// R14: Extension flag announces sixteen-bit extension
// R15: Transmit CRC flag one; accept legacy zero
// R16: Segment and user access presence flags
// R17: Group type 0 general, 1 access messages
// R18: Group continuity advances on new content
// R19: Repetition count; 1111 means endless
// R20: Last-segment flag and fifteen-bit segment number
// R21: Access field: reserved, identifier flag, length
// R22: Sixteen-bit object identifier, then user address
// R23: Group CRC same scheme over whole group; the receive check skips packets with neither first nor last set
// R24: Group starts first packet, CRC ends last
// R25: Header packed length, counter, flags, address, command, length
// R26: Discard on CRC, sequence or length error
package bpmf_pkg;

	// ************************************************************
	// Packet layout
	// ************************************************************
	localparam logic [6:0]  HDR_BYTES   = 7'h03;
	localparam logic [6:0]  CRC_BYTES   = 7'h02;
	localparam logic [6:0]  PKT_TOTAL [0:3] = '{7'h18, 7'h30, 7'h48, 7'h60};
	localparam logic [6:0]  PKT_FIELD [0:3] = '{7'h13, 7'h2b, 7'h43, 7'h5b};
	localparam logic [9:0]  PAD_ADDR    = 10'h000;
	localparam int unsigned ADDR_COUNT  = 1024;
	localparam int unsigned MAX_FIELD   = 91;

	typedef struct packed {
		logic [1:0] len_code;
		logic [1:0] seq;
		logic       first;
		logic       last;
		logic [9:0] addr;
		logic       command;
		logic [6:0] useful_len;
	} bpmf_hdr_t;

	// ************************************************************
	// CRC
	// ************************************************************
	localparam logic [15:0] CRC_POLY    = 16'h1021;
	localparam logic [15:0] CRC_PRESET  = 16'hffff;
	localparam logic [15:0] CRC_RESIDUE = 16'h1d0f;

	// ************************************************************
	// Group header bits, counted in the first payload byte
	// ************************************************************
	localparam int unsigned GH_EXT  = 7;
	localparam int unsigned GH_CRC  = 6;
	localparam int unsigned GH_SEG  = 5;
	localparam int unsigned GH_UA   = 4;

	// ************************************************************
	// Register map (byte offsets) and fields
	// ************************************************************
	localparam logic [11:0] REG_CTRL   = 12'h000;
	localparam logic [11:0] REG_TXDATA = 12'h004;
	localparam logic [11:0] REG_STATUS = 12'h008;
	localparam logic [11:0] REG_RXHDR  = 12'h00c;
	localparam logic [11:0] REG_RXDATA = 12'h010;
	localparam logic [11:0] REG_GRPHDR = 12'h014;

	localparam int unsigned CTRL_START = 0;
	localparam int unsigned CTRL_GROUP = 1;
	localparam int unsigned CTRL_LEN   = 2;
	localparam int unsigned CTRL_FIRST = 4;
	localparam int unsigned CTRL_LAST  = 5;
	localparam int unsigned CTRL_CMD   = 6;
	localparam int unsigned CTRL_ULEN  = 8;
	localparam int unsigned CTRL_ADDR  = 16;

	localparam int unsigned ST_BUSY    = 0;
	localparam int unsigned ST_RX_OK   = 1;
	localparam int unsigned ST_CRC_ERR = 2;
	localparam int unsigned ST_SEQ_ERR = 3;
	localparam int unsigned ST_LEN_ERR = 4;
	localparam int unsigned ST_GRP_OK  = 5;
	localparam int unsigned ST_GRP_ERR = 6;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b01,
		TX_SEND = 2'b10
	} bpmf_tx_state_t;

	function automatic logic [15:0] bpmf_crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--)
		begin
			if (r[15] ^ d[i])
				r = {r[14:0], 1'b0} ^ CRC_POLY;
			else
				r = {r[14:0], 1'b0};
		end
		return r;
	endfunction

endpackage

// ### sim/bpmf_dev_model.sv
/*
 * Far-side framer model: sinks the host's transmit byte stream and plays
 * prepared packets into the host's receive port.
 * Assumes the host shares clk_sys; the bench builds every packet it plays.
 */
module bpmf_dev_model (
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic       stall,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid,
	output logic            tx_ready,
	output logic      [7:0] rx_data,
	output logic            rx_valid
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [7:0] got[$];
	logic [1:0] ph;

	initial
	begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		tx_ready = 1'b0;
	end

	// ************************************************************
	// Transmit sink
	// ************************************************************
	// Slow mode refuses one byte in three so the host must hold its offer
	always @(posedge clk_sys)
	begin
		ph <= (reset || ph == 2'h2) ? 2'h0 : ph + 2'h1;
		tx_ready <= !reset && !(stall && ph == 2'h0);
		if (!reset && tx_valid && tx_ready)
			got.push_back(tx_data);
	end

	// ************************************************************
	// Receive source
	// ************************************************************
	// Idle bus shows the inverse of the last byte, never a stale copy
	task automatic send_pkt(input logic [7:0] b[$]);
		for (int i = 0; i < b.size(); i++)
		begin
			if (i == 5)
			begin
				@(posedge clk_sys);
				rx_valid <= 1'b0;
				rx_data <= ~b[i - 1];
			end
			@(posedge clk_sys);
			rx_valid <= 1'b1;
			rx_data <= b[i];
		end
		@(posedge clk_sys);
		rx_valid <= 1'b0;
		rx_data <= ~b[b.size() - 1];
	endtask
endmodule

// ### sim/bpmf_host_tb.sv
/*
 * Self-checking bench for the packet-mode host: APB tasks, transmit and
 * receive packet scenarios against packets built here.
 * Assumes the far-side model in bpmf_dev_model.
 */
module bpmf_host_tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk_sys, reset, psel, penable, pwrite, stall;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic        pready, pslverr, errv, tx_valid, tx_ready, rx_valid;
	logic [7:0]  tx_data, rx_data;
	logic [7:0]  pay_q[$], exp_q[$];
	int          n_errors, n_tests, cyc;
	int          ul[5] = '{0, 43, 20, 91, 19};

	bpmf_host dut (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid));
	bpmf_dev_model dev (.clk_sys(clk_sys), .reset(reset), .stall(stall), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid));

	always #25 clk_sys = ~clk_sys;

	// ************************************************************
	// Helpers
	// ************************************************************
	task report_and_stop;
		if (n_errors == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			n_errors++;
			report_and_stop;
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
			@(posedge clk_sys);
		while (pready !== 1'b1);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic [15:0] crc16(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (b[i])
			for (int k = 7; k >= 0; k--)
				c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i][k]) ? 16'h1021 : 16'h0000);
		return c;
	endfunction

	// Header, payload, zero fill to the field size, inverted CRC high first
	task automatic mk(input logic [23:0] h);
		int          fld;
		logic [15:0] c;
		fld = 24 * (int'(h[23:22]) + 1) - 5;
		exp_q = {h[23:16], h[15:8], h[7:0]};
		foreach (pay_q[i])
			exp_q.push_back(pay_q[i]);
		while (exp_q.size() < fld + 3)
			exp_q.push_back(8'h00);
		c = ~crc16(exp_q);
		exp_q.push_back(c[15:8]);
		exp_q.push_back(c[7:0]);
	endtask

	// ************************************************************
	// Packet tasks
	// ************************************************************
	task automatic tx_pkt(input logic [1:0] lc, input logic [1:0] sq, input logic [1:0] fl, input logic grp,
		input logic cmd, input logic [9:0] ad);
		foreach (pay_q[i])
			apb(1'b1, bpmf_pkg::REG_TXDATA, {24'h0, pay_q[i]});
		dev.got.delete();
		apb(1'b1, bpmf_pkg::REG_CTRL, {6'h0, ad, 1'b0, 7'(pay_q.size()), 1'b0, cmd, fl[0], fl[1], lc, grp, 1'b1});
		apb(1'b0, bpmf_pkg::REG_STATUS, 32'h0);
		chk("busy", 32'h1, {31'h0, rdv[0]});
		mk({lc, sq, grp ? fl : 2'b00, ad, cmd, 7'(pay_q.size())});
		while (dev.got.size() < exp_q.size())
			@(posedge clk_sys);
		repeat (4) @(posedge clk_sys);
		chk("tx_count", 32'(exp_q.size()), 32'(dev.got.size()));
		foreach (exp_q[i])
			chk("tx_byte", {24'h0, exp_q[i]}, {24'h0, dev.got[i]});
		apb(1'b0, bpmf_pkg::REG_STATUS, 32'h0);
		chk("idle", 32'h0, {31'h0, rdv[0]});
	endtask

	task automatic rx_pkt(input logic [23:0] h, input int nb, input logic bad, input logic [3:0] est);
		pay_q = {};
		for (int i = 0; i < nb; i++)
			pay_q.push_back(8'(i + 17));
		mk(h);
		if (bad)
			exp_q[exp_q.size() - 1] ^= 8'h01;
		dev.send_pkt(exp_q);
		apb(1'b0, bpmf_pkg::REG_STATUS, 32'h0);
		chk("rx_status", {28'h0, est}, {28'h0, rdv[4:1]});
		if (est == 4'h1)
		begin
			apb(1'b0, bpmf_pkg::REG_RXHDR, 32'h0);
			chk("rx_hdr", {8'h0, h}, rdv);
			foreach (pay_q[i])
			begin
				apb(1'b0, bpmf_pkg::REG_RXDATA, 32'h0);
				chk("rx_byte", {24'h0, pay_q[i]}, {24'h0, rdv[7:0]});
			end
		end
		apb(1'b1, bpmf_pkg::REG_STATUS, 32'h0000007e);
	endtask

	// One-packet group with CRC flag set; flip corrupts the group CRC only
	task automatic grp_rx(input logic [1:0] sq, input logic [7:0] b1, input logic [7:0] flip,
		input logic [5:0] est);
		logic [15:0] c;
		pay_q = '{8'h40, b1, 8'hc3, 8'h5a};
		c = ~crc16(pay_q);
		pay_q.push_back(c[15:8]);
		pay_q.push_back(c[7:0] ^ flip);
		mk({2'b00, sq, 2'b11, 10'h00a, 1'b0, 7'd6});
		dev.send_pkt(exp_q);
		apb(1'b0, bpmf_pkg::REG_STATUS, 32'h0);
		chk("grp_status", {26'h0, est}, {26'h0, rdv[6:1]});
		apb(1'b0, bpmf_pkg::REG_GRPHDR, 32'h0);
		chk("grp_hdr", {8'h40, b1, 8'hc3, 8'h5a}, rdv);
		apb(1'b1, bpmf_pkg::REG_STATUS, 32'h0000007e);
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial
	begin
		clk_sys = 1'b0;
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		stall = 1'b0;
		n_errors = 0;
		n_tests = 0;
		cyc = 0;
		repeat (4) @(posedge clk_sys);
		reset <= 1'b0;
		apb(1'b0, bpmf_pkg::REG_STATUS, 32'h0);
		chk("status_reset", 32'h0, rdv);
		apb(1'b0, 12'h018, 32'h0);
		chk("unmapped_err", 32'h1, {31'h0, errv});
		chk("unmapped_data", 32'h0, rdv);
		// Every length code on one address; the fifth packet shows the wrap
		for (int k = 0; k < 5; k++)
		begin
			stall <= k[0];
			pay_q = {};
			for (int j = 0; j < ul[k]; j++)
				pay_q.push_back(8'(j * 37 + k + 1));
			tx_pkt(k[1:0], k[1:0], 2'b11, 1'b0, k[0], 10'h155);
		end
		apb(1'b0, bpmf_pkg::REG_CTRL, 32'h0);
		chk("ctrl_start", 32'h0, {31'h0, rdv[0]});
		pay_q = '{8'h70, 8'h01};
		tx_pkt(2'b00, 2'b00, 2'b10, 1'b1, 1'b0, 10'h2aa);
		pay_q = {};
		tx_pkt(2'b00, 2'b00, 2'b00, 1'b0, 1'b0, 10'h000);
		stall <= 1'b0;
		rx_pkt({2'b00, 2'b00, 2'b00, 10'h009, 1'b0, 7'd3}, 3, 1'b0, 4'h1);
		rx_pkt({2'b00, 2'b01, 2'b00, 10'h009, 1'b0, 7'd3}, 3, 1'b1, 4'h2);
		rx_pkt({2'b00, 2'b10, 2'b00, 10'h009, 1'b0, 7'd3}, 3, 1'b0, 4'h4);
		rx_pkt({2'b00, 2'b11, 2'b00, 10'h009, 1'b0, 7'd20}, 3, 1'b0, 4'h8);
		rx_pkt({2'b00, 2'b00, 2'b00, 10'h000, 1'b0, 7'd0}, 0, 1'b0, 4'h0);
		rx_pkt({2'b11, 2'b00, 2'b00, 10'h009, 1'b1, 7'd91}, 91, 1'b0, 4'h1);
		grp_rx(2'b00, 8'h00, 8'h00, 6'h11);
		grp_rx(2'b01, 8'h10, 8'h01, 6'h21);
		apb(1'b0, bpmf_pkg::REG_STATUS, 32'h0);
		chk("status_clear", 32'h0, rdv);
		report_and_stop;
	end
endmodule
